// >>> cptc_regs.sv
// Core register bank: stack, data pointer, power and timer control
// Notes on behaviour
// - Eight-bit stack pointer register at 81h
// - Data pointer pair, low 82h, high 83h
// - Power bit 7 doubles serial baud rate
// - Power bit 6 selects framing-error view
// - Brownout flag set by brownout or power-on
// - Power-on flag set at power-on reset
// - Power bits 3,2 are plain user flags
// - Power bit 1 requests deep sleep
// - Power bit 0 requests light sleep
// - Timer1 overflow flag, cleared on vectoring
// - Timer1 run control bit 6
// - Timer0 overflow flag, cleared on vectoring
// - Timer0 run control bit 4
// - External irq1 flag, edge or level
// - Bit 2 selects irq1 edge or level
// - External irq0 flag, edge or level
// - Bit 0 selects irq0 edge or level
module cptc_regs
    import cptc_pkg::*;
#(
    // Register width; every register of the bank is one byte
    parameter int DATA_W = 8,
    // External interrupt channels served by the timer control register
    parameter int IRQ_CH = 2
)
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port
    input wire cptc_bus_type bus,
    output logic [7:0] rdata,
    // Hardware events
    input wire cptc_event_type evt,
    // External interrupt pins, active low, asynchronous
    input wire logic extIrq0Pin_n,
    input wire logic extIrq1Pin_n,
    // Control outputs
    output logic [15:0] dataPointerPair,
    output logic [7:0] stackTopPointer,
    output logic baudDoubler,
    output logic frameErrorSelect,
    output logic deepSleepRequest,
    output logic lightSleepRequest,
    output logic timer1Run,
    output logic timer0Run,
    output logic extIrq1Flag,
    output logic extIrq0Flag,
    output logic timer1Overflow,
    output logic timer0Overflow
);
    cptc_state_type state_ff;
    cptc_state_type nxt_state;

    logic x0Level;
    logic x1Level;
    logic [IRQ_CH-1:0][2:0] pinSync;
    logic [IRQ_CH-1:0] pinPrev;
    logic [IRQ_CH-1:0] pinLevel;
    logic wrStack;
    logic wrDpLow;
    logic wrDpHigh;
    logic wrPower;
    logic wrTimer;
    logic rdStack;
    logic rdDpLow;
    logic rdDpHigh;
    logic rdPower;
    logic rdTimer;
    logic stackInc;
    logic stackDec;
    logic setBrownout;
    logic setPowerOn;

    // Elaboration checks: the field map is fixed at bytes and two pins
    if (DATA_W != 8)
    begin : gWidthCheck
        $error("cptc_regs: DATA_W must be 8");
    end
    if (IRQ_CH != 2)
    begin : gIrqCheck
        $error("cptc_regs: IRQ_CH must be 2");
    end

    // Channel views of the synchroniser stages, irq1 above irq0
    assign pinSync = {state_ff.x1Sync, state_ff.x0Sync};
    assign pinPrev = {state_ff.x1Prev, state_ff.x0Prev};

    // Pin filter: change counts once stages two and three agree
    for (genvar ch = 0; ch < IRQ_CH; ch++)
    begin : gPinFilter
        logic settled;
        assign settled = pinSync[ch][1] == pinSync[ch][2];
        assign pinLevel[ch] = settled ? pinSync[ch][2] : pinPrev[ch];
    end
    assign x0Level = pinLevel[0];
    assign x1Level = pinLevel[1];

    // Write decode, one strobe per register
    assign wrStack = bus.wr && bus.addr == OFF_STACK;
    assign wrDpLow = bus.wr && bus.addr == OFF_DPLOW;
    assign wrDpHigh = bus.wr && bus.addr == OFF_DPHIGH;
    assign wrPower = bus.wr && bus.addr == OFF_POWER;
    assign wrTimer = bus.wr && bus.addr == OFF_TIMER;

    // Read decode; an unmapped address hits none of these
    assign rdStack = bus.rd && bus.addr == OFF_STACK;
    assign rdDpLow = bus.rd && bus.addr == OFF_DPLOW;
    assign rdDpHigh = bus.rd && bus.addr == OFF_DPHIGH;
    assign rdPower = bus.rd && bus.addr == OFF_POWER;
    assign rdTimer = bus.rd && bus.addr == OFF_TIMER;

    // Push and pop in one cycle cancel out
    assign stackInc = evt.stackPush && !evt.stackPop;
    assign stackDec = evt.stackPop && !evt.stackPush;

    // Hardware sets of the power flags; power-on raises both
    assign setBrownout = evt.brownout || evt.powerOn;
    assign setPowerOn = evt.powerOn;

    // Next state
    always_comb
    begin
        nxt_state = state_ff;
        nxt_state.x0Sync = {state_ff.x0Sync[1:0], extIrq0Pin_n};
        nxt_state.x1Sync = {state_ff.x1Sync[1:0], extIrq1Pin_n};
        nxt_state.x0Prev = x0Level;
        nxt_state.x1Prev = x1Level;

        // Stack pointer: software write wins over push or pop
        if (wrStack)
        begin
            nxt_state.stackTop = bus.wdata;
        end
        else if (stackInc)
        begin
            nxt_state.stackTop = state_ff.stackTop + 8'h01;
        end
        else if (stackDec)
        begin
            nxt_state.stackTop = state_ff.stackTop - 8'h01;
        end

        // Data pointer bytes
        if (wrDpLow)
        begin
            nxt_state.dpLow = bus.wdata;
        end
        if (wrDpHigh)
        begin
            nxt_state.dpHigh = bus.wdata;
        end

        // Power control: plain bits from software
        if (wrPower)
        begin
            nxt_state.power = bus.wdata;
        end
        // Wake ends any sleep request
        if (evt.wake)
        begin
            nxt_state.power[PC_DEEP] = 1'b0;
            nxt_state.power[PC_LIGHT] = 1'b0;
        end
        // Hardware sets win over software clears
        if (setBrownout)
        begin
            nxt_state.power[PC_BOF] = 1'b1;
        end
        if (setPowerOn)
        begin
            nxt_state.power[PC_PON] = 1'b1;
        end

        // Timer control: software write first
        if (wrTimer)
        begin
            nxt_state.timer = bus.wdata;
        end
        // Overflow flags: vector clears, overflow sets and wins
        if (evt.t1Vector)
        begin
            nxt_state.timer[TC_T1OV] = 1'b0;
        end
        if (evt.t1Overflow)
        begin
            nxt_state.timer[TC_T1OV] = 1'b1;
        end
        if (evt.t0Vector)
        begin
            nxt_state.timer[TC_T0OV] = 1'b0;
        end
        if (evt.t0Overflow)
        begin
            nxt_state.timer[TC_T0OV] = 1'b1;
        end

        // External irq1: level follows inverted pin, edge latches fall
        if (!nxt_state.timer[TC_X1TYPE])
        begin
            nxt_state.timer[TC_X1FLAG] = !x1Level;
        end
        else
        begin
            if (evt.x1Vector)
            begin
                nxt_state.timer[TC_X1FLAG] = 1'b0;
            end
            if (state_ff.x1Prev && !x1Level)
            begin
                nxt_state.timer[TC_X1FLAG] = 1'b1;
            end
        end

        // External irq0: same scheme as irq1
        if (!nxt_state.timer[TC_X0TYPE])
        begin
            nxt_state.timer[TC_X0FLAG] = !x0Level;
        end
        else
        begin
            if (evt.x0Vector)
            begin
                nxt_state.timer[TC_X0FLAG] = 1'b0;
            end
            if (state_ff.x0Prev && !x0Level)
            begin
                nxt_state.timer[TC_X0FLAG] = 1'b1;
            end
        end

        // Read data, one cycle after the strobe; unmapped reads zero
        nxt_state.rdata = 8'h00;
        if (rdStack)
        begin
            nxt_state.rdata = state_ff.stackTop;
        end
        else if (rdDpLow)
        begin
            nxt_state.rdata = state_ff.dpLow;
        end
        else if (rdDpHigh)
        begin
            nxt_state.rdata = state_ff.dpHigh;
        end
        else if (rdPower)
        begin
            nxt_state.rdata = state_ff.power;
        end
        else if (rdTimer)
        begin
            nxt_state.rdata = state_ff.timer;
        end
    end

    // State register, synchronous reset; pins idle high
    always_ff @(posedge clk)
    begin
        if (!rst_n)
        begin
            state_ff.stackTop <= RST_STACK;
            state_ff.dpLow <= RST_DP;
            state_ff.dpHigh <= RST_DP;
            state_ff.power <= RST_POWER;
            state_ff.timer <= RST_TIMER;
            state_ff.rdata <= 8'h00;
            state_ff.x0Sync <= 3'h7;
            state_ff.x1Sync <= 3'h7;
            state_ff.x0Prev <= 1'b1;
            state_ff.x1Prev <= 1'b1;
        end
        else
        begin
            state_ff <= nxt_state;
        end
    end

    // Outputs straight from the state register
    assign rdata = state_ff.rdata;
    assign stackTopPointer = state_ff.stackTop;
    assign dataPointerPair = {state_ff.dpHigh, state_ff.dpLow};
    assign baudDoubler = state_ff.power[PC_BAUD];
    assign frameErrorSelect = state_ff.power[PC_FESEL];
    assign deepSleepRequest = state_ff.power[PC_DEEP];
    assign lightSleepRequest = state_ff.power[PC_LIGHT];
    assign timer1Run = state_ff.timer[TC_T1RUN];
    assign timer0Run = state_ff.timer[TC_T0RUN];
    assign timer1Overflow = state_ff.timer[TC_T1OV];
    assign timer0Overflow = state_ff.timer[TC_T0OV];
    assign extIrq1Flag = state_ff.timer[TC_X1FLAG];
    assign extIrq0Flag = state_ff.timer[TC_X0FLAG];
endmodule

// >>> cptc_pkg.sv
// Package for the core power and timer control register bank
package cptc_pkg;
    // Register offsets
    localparam logic [7:0] OFF_STACK = 8'h81;
    localparam logic [7:0] OFF_DPLOW = 8'h82;
    localparam logic [7:0] OFF_DPHIGH = 8'h83;
    localparam logic [7:0] OFF_POWER = 8'h87;
    localparam logic [7:0] OFF_TIMER = 8'h88;
    // Reset values
    localparam logic [7:0] RST_STACK = 8'h07;
    localparam logic [7:0] RST_DP = 8'h00;
    localparam logic [7:0] RST_POWER = 8'h00;
    localparam logic [7:0] RST_TIMER = 8'h00;
    // Power control field positions
    localparam int PC_BAUD = 7;
    localparam int PC_FESEL = 6;
    localparam int PC_BOF = 5;
    localparam int PC_PON = 4;
    localparam int PC_UHI = 3;
    localparam int PC_ULO = 2;
    localparam int PC_DEEP = 1;
    localparam int PC_LIGHT = 0;
    // Timer control field positions
    localparam int TC_T1OV = 7;
    localparam int TC_T1RUN = 6;
    localparam int TC_T0OV = 5;
    localparam int TC_T0RUN = 4;
    localparam int TC_X1FLAG = 3;
    localparam int TC_X1TYPE = 2;
    localparam int TC_X0FLAG = 1;
    localparam int TC_X0TYPE = 0;

    // Software register port
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } cptc_bus_type;

    // Hardware events into the bank
    typedef struct packed {
        logic t1Overflow;
        logic t0Overflow;
        logic t1Vector;
        logic t0Vector;
        logic x1Vector;
        logic x0Vector;
        logic brownout;
        logic powerOn;
        logic stackPush;
        logic stackPop;
        logic wake;
    } cptc_event_type;

    // Whole module state
    typedef struct packed {
        logic [7:0] stackTop;
        logic [7:0] dpLow;
        logic [7:0] dpHigh;
        logic [7:0] power;
        logic [7:0] timer;
        logic [7:0] rdata;
        logic [2:0] x0Sync;
        logic [2:0] x1Sync;
        logic x0Prev;
        logic x1Prev;
    } cptc_state_type;
endpackage

// >>> cptc_regs_monitor.sv
// Concurrent checks on the register bank ports
module cptc_regs_monitor
    import cptc_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Register port and events
    input wire cptc_bus_type bus,
    input wire logic [7:0] rdata,
    input wire cptc_event_type evt,
    input wire logic extIrq0Pin_n,
    // Watched outputs
    input wire logic [15:0] dataPointerPair,
    input wire logic [7:0] stackTopPointer,
    input wire logic deepSleepRequest,
    input wire logic lightSleepRequest,
    input wire logic extIrq0Flag,
    input wire logic timer1Overflow,
    input wire logic timer0Overflow
);
    timeunit 1ns;
    timeprecision 1ns;
    logic x0Type_ff;
    // Irq0 trigger type as software last wrote it
    always_ff @(posedge clk)
    begin
        if (!rst_n)
            x0Type_ff <= 1'b0;
        else if (bus.wr && bus.addr == OFF_TIMER)
            x0Type_ff <= bus.wdata[TC_X0TYPE];
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // Irq0 pin held low long enough to pass the filter
    sequence lowLevel0;
        (!extIrq0Pin_n && !x0Type_ff)[*7];
    endsequence
    stack_read_a: assert property (bus.rd && bus.addr == OFF_STACK
        |=> rdata == $past(stackTopPointer)) else $error("stack read wrong");
    rd_idle_a: assert property (!bus.rd |=> rdata == 8'h00) else $error("read data not idle");
    dp_high_a: assert property (bus.wr && bus.addr == OFF_DPHIGH
        |=> dataPointerPair[15:8] == $past(bus.wdata)) else $error("pointer high wrong");
    stack_push_a: assert property (evt.stackPush && !evt.stackPop && !bus.wr
        |=> stackTopPointer == $past(stackTopPointer) + 8'h01) else $error("push wrong");
    wake_clear_a: assert property (evt.wake
        |=> !deepSleepRequest && !lightSleepRequest) else $error("wake left sleep");
    sleep_write_a: assert property (bus.wr && bus.addr == OFF_POWER && !evt.wake
        |=> deepSleepRequest == $past(bus.wdata[PC_DEEP])) else $error("sleep wrong");
    ovf_set_a: assert property (evt.t1Overflow |=> timer1Overflow)
        else $error("overflow not set");
    vec_clear_a: assert property (evt.t0Vector && !evt.t0Overflow && !bus.wr
        |=> !timer0Overflow) else $error("vector did not clear");
    level_follow_a: assert property (lowLevel0 |-> extIrq0Flag)
        else $error("level flag wrong");
endmodule

bind cptc_regs cptc_regs_monitor mon (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata),
    .evt(evt), .extIrq0Pin_n(extIrq0Pin_n), .dataPointerPair(dataPointerPair),
    .stackTopPointer(stackTopPointer), .deepSleepRequest(deepSleepRequest),
    .lightSleepRequest(lightSleepRequest), .extIrq0Flag(extIrq0Flag),
    .timer1Overflow(timer1Overflow), .timer0Overflow(timer0Overflow));

// >>> cptc_regs_tb_top.sv
// Self-checking bench for the register bank
module cptc_regs_tb_top
    import cptc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    cptc_bus_type bus = '0;
    cptc_event_type evt = '0;
    logic extIrq0Pin_n = 1'b1;
    logic extIrq1Pin_n = 1'b1;
    logic [7:0] rdata;
    logic [15:0] dataPointerPair;
    logic [7:0] stackTopPointer;
    logic baudDoubler, frameErrorSelect, deepSleepRequest, lightSleepRequest;
    logic timer1Run, timer0Run, extIrq1Flag, extIrq0Flag, timer1Overflow, timer0Overflow;
    int err_total = 0;
    int cmp_count = 0;
    int cyc = 0;

    cptc_regs dut (.clk(clk), .rst_n(rst_n), .bus(bus), .rdata(rdata), .evt(evt),
        .extIrq0Pin_n(extIrq0Pin_n), .extIrq1Pin_n(extIrq1Pin_n),
        .dataPointerPair(dataPointerPair), .stackTopPointer(stackTopPointer),
        .baudDoubler(baudDoubler), .frameErrorSelect(frameErrorSelect),
        .deepSleepRequest(deepSleepRequest), .lightSleepRequest(lightSleepRequest),
        .timer1Run(timer1Run), .timer0Run(timer0Run), .extIrq1Flag(extIrq1Flag),
        .extIrq0Flag(extIrq0Flag), .timer1Overflow(timer1Overflow),
        .timer0Overflow(timer0Overflow));

    // Clock, 20 ns period
    initial
    begin
        forever #10 clk = ~clk;
    end

    task automatic give_verdict;
        $display("Comparisons %0d, mismatches %0d", cmp_count, err_total);
        if (err_total == 0 && cmp_count > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            err_total++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk);
        bus.wr <= 1'b0;
        #1;
    endtask

    // Read strobe, data taken in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk);
        bus.rd <= 1'b0;
        #1;
        chk(16'(rdata), 16'(e));
    endtask

    // One-cycle hardware event pulse
    task automatic pulse(input cptc_event_type e);
        @(posedge clk);
        evt <= e;
        @(posedge clk);
        evt <= '0;
        #1;
    endtask

    // Hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 2000)
        begin
            err_total++;
            give_verdict;
        end
    end

    // Main sequence
    initial
    begin
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_STACK, RST_STACK);
        rd(OFF_DPHIGH, RST_DP);
        rd(OFF_POWER, RST_POWER);
        rd(OFF_TIMER, RST_TIMER);
        rd(8'h84, 8'h00);
        wr(OFF_DPLOW, 8'ha5);
        wr(OFF_DPHIGH, 8'h3c);
        chk(dataPointerPair, 16'h3ca5);
        rd(OFF_DPLOW, 8'ha5);
        wr(OFF_STACK, 8'hff);
        pulse(11'h004);
        chk(16'(stackTopPointer), 16'h0000);
        pulse(11'h006);
        chk(16'(stackTopPointer), 16'h0000);
        pulse(11'h002);
        rd(OFF_STACK, 8'hff);
        wr(OFF_POWER, 8'hcc);
        chk(16'({baudDoubler, frameErrorSelect, deepSleepRequest}), 16'h0006);
        chk(16'(frameErrorSelect), 16'h0001);
        rd(OFF_POWER, 8'hcc);
        wr(OFF_POWER, 8'h03);
        chk(16'({deepSleepRequest, lightSleepRequest}), 16'h0003);
        chk(16'(lightSleepRequest), 16'h0001);
        pulse(11'h001);
        chk(16'({deepSleepRequest, lightSleepRequest}), 16'h0000);
        wr(OFF_POWER, 8'h01);
        chk(16'({deepSleepRequest, lightSleepRequest}), 16'h0001);
        pulse(11'h001);
        chk(16'(lightSleepRequest), 16'h0000);
        pulse(11'h008);
        rd(OFF_POWER, 8'h30);
        wr(OFF_POWER, 8'h00);
        pulse(11'h010);
        rd(OFF_POWER, 8'h20);
        wr(OFF_POWER, 8'h00);
        rd(OFF_POWER, 8'h00);
        wr(OFF_TIMER, 8'h50);
        chk(16'({timer1Run, timer0Run}), 16'h0003);
        chk(16'(timer1Run), 16'h0001);
        pulse(11'h600);
        rd(OFF_TIMER, 8'hf0);
        pulse(11'h080);
        chk(16'({timer1Overflow, timer0Overflow}), 16'h0002);
        wr(OFF_TIMER, 8'ha4);
        rd(OFF_TIMER, 8'ha4);
        chk(16'({timer1Run, timer0Run}), 16'h0000);
        // Irq1 edge mode, irq0 level mode
        @(posedge clk);
        extIrq0Pin_n <= 1'b0;
        extIrq1Pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk(16'({extIrq1Flag, extIrq0Flag}), 16'h0003);
        pulse(11'h060);
        chk(16'({extIrq1Flag, extIrq0Flag}), 16'h0001);
        @(posedge clk);
        extIrq0Pin_n <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk(16'(extIrq0Flag), 16'h0000);
        // Irq1 level mode with pin low, irq0 edge mode
        wr(OFF_TIMER, 8'h01);
        chk(16'({extIrq1Flag, extIrq0Flag}), 16'h0002);
        @(posedge clk);
        extIrq0Pin_n <= 1'b0;
        repeat (8) @(posedge clk);
        #1;
        chk(16'({extIrq1Flag, extIrq0Flag}), 16'h0003);
        @(posedge clk);
        extIrq0Pin_n <= 1'b1;
        extIrq1Pin_n <= 1'b1;
        repeat (8) @(posedge clk);
        #1;
        chk(16'({extIrq1Flag, extIrq0Flag}), 16'h0001);
        pulse(11'h020);
        chk(16'(extIrq0Flag), 16'h0000);
        // Reset in mid-run restores the reset values
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        rd(OFF_STACK, RST_STACK);
        rd(OFF_TIMER, RST_TIMER);
        give_verdict;
    end
endmodule
